// ==== hdl/cib_core.sv ====
// Execution unit for I/O bit, branch, shift, flag, transfer-bit and pointer loads.
// Assumes one AHB-Lite master on sys_clk and asynchronous event pins.
// Summary of operation
// - Single-bit set, clear and skip tests reach only the lowest 32 I/O addresses.
// - A single-bit set or clear rewrites the whole I/O register it read.
// - Event flags are cleared by writing a one to their position.
// - Port reads and writes use I/O addresses 0 to 63, seen at that plus 0x20 in data space.
// - The port opcode carries a six-bit I/O address and so reaches exactly 64 locations.
// - Extended I/O from 0x60 upward is reached only by data-space loads.
// - Overflow-clear and interrupt branches jump to PC plus offset plus one, one cycle or two.
// - The I/O bit clear forces the bit to zero in two cycles without touching flags.
// - Logical shifts fill with zero and update zero, carry, negative and overflow in one cycle.
// - Rotates through carry feed old carry in and shifted-out bit to carry in one cycle.
// - Each flag instruction sets or clears one flag in one cycle and leaves the rest.
// - Bit store copies a register bit to the transfer flag and bit load copies it back.
// - Pointer loads take two cycles, plain or with post-increment or pre-decrement of the pointer.
// - The displaced load reads pointer plus displacement and leaves the pointer alone.
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module cib_core
	import cib_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Event pins and core state.
	input wire logic [7:0] evtIn,
	output logic [7:0] cpuFlags,
	output logic busy
);
	localparam int AW = $clog2(DMEM_DEPTH);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic accR;
	logic wrR;
	logic [31:0] addrR;
	cib_state_t stR;
	cib_state_t stNxt;
	logic [15:0] opR;
	logic [15:0] pcR;
	logic [7:0] flagsR;
	logic [7:0] gprR [32];
	logic [1:0] cycR;
	logic illR;
	logic dropR;
	logic [7:0] s1R, s2R, s3R, stbR, evtR;
	logic [7:0] memRdA;
	logic [7:0] memRdB;

	// Data-space read with the event flag register overlaid.
	function automatic logic [7:0] dsRead(input logic [15:0] a, input logic [7:0] m,
		input logic [7:0] e);
		dsRead = (a == EVT_DS) ? e : m;
	endfunction

	// Pointer pair low register from the pointer select.
	function automatic logic [4:0] ptrLo(input logic [1:0] s);
		ptrLo = (s == 2'h2) ? PTR_Z_LO : (s == 2'h1) ? PTR_Y_LO : PTR_X_LO;
	endfunction

	// Shift and rotate unit, returns carry and result.
	function automatic logic [8:0] shiftCalc(input logic [2:0] k, input logic [7:0] v,
		input logic c);
		case (k)
			SH_LSL: shiftCalc = {v[7], v[6:0], 1'b0};
			SH_LSR: shiftCalc = {v[0], 1'b0, v[7:1]};
			SH_ROL: shiftCalc = {v[7], v[6:0], c};
			SH_ROR: shiftCalc = {v[0], c, v[7:1]};
			SH_ASR: shiftCalc = {v[0], v[7], v[7:1]};
			default: shiftCalc = {c, v};
		endcase
	endfunction

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	// Address phase taken, data phase write and register selects.
	wire take = hsel & hready & htrans[1];
	wire busWr = accR & wrR;
	wire selInstr = (addrR == ADDR_INSTR);
	wire selStat = (addrR == ADDR_STAT);
	wire selPc = (addrR == ADDR_PC);
	wire selGpr = (addrR[31:7] == GPR_BASE[31:7]);
	wire selMem = (addrR[31:11] == MEM_BASE[31:11]);
	wire [15:0] busDs = {7'h00, addrR[AW+1:2]};
	wire [AW-1:0] addrB = accR ? addrR[AW+1:2] : haddr[AW+1:2];
	wire [7:0] busMem = dsRead(busDs, memRdB, evtR);
	wire [31:0] statW = {pcR, 2'b00, cycR, 1'b0, dropR, illR, stR != S_IDLE, flagsR};
	wire [31:0] busRd = selStat ? statW : selPc ? {16'h0000, pcR} :
		selGpr ? {24'h000000, gprR[addrR[6:2]]} :
		selMem ? {24'h000000, busMem} : 32'h0000_0000;

	// ------------------------------------------------------------
	// Instruction decode
	// ------------------------------------------------------------
	// Field extraction for the executing opcode.
	wire ex = (stR == S_EXEC);
	wire fin = (stR == S_FIN);
	wire [3:0] cls = opR[15:12];
	wire [4:0] dSel = opR[4:0];
	wire [4:0] portD = opR[10:6];
	wire [4:0] tReg = opR[7:3];
	wire [2:0] bSel = opR[2:0];
	wire [2:0] shK = opR[10:8];
	wire [1:0] pMode = opR[9:8];
	wire fClr = opR[3];
	wire [7:0] srcD = gprR[dSel];
	wire srcTop = srcD[7];
	wire srcBot = srcD[0];
	wire cFlag = flagsR[FL_C];
	wire tBit = gprR[tReg][bSel];
	wire legal = (cls <= CL_DISP) && !(cls == CL_SH && shK > SH_ASR);
	wire [1:0] pSel = (cls == CL_DISP) ? (opR[11] ? 2'h2 : 2'h1) : opR[11:10];
	wire [4:0] pLo = ptrLo(pSel);
	wire [15:0] ptrCur = {gprR[pLo | 5'h01], gprR[pLo]};
	wire [15:0] ptrNew = (pMode == PM_PRE) ? ptrCur - 16'h0001 : ptrCur + 16'h0001;
	wire [15:0] ioDs = {10'h000, opR[5:0]} + IO_DS_OFS;
	wire [15:0] bitDs = {11'h000, opR[7:3]} + IO_DS_OFS;
	wire [15:0] coreDs = (cls == CL_IN || cls == CL_OUT) ? ioDs : (cls == CL_BIT) ? bitDs :
		(cls == CL_DISP) ? ptrCur + {10'h000, opR[10:5]} :
		(pMode == PM_PRE) ? ptrNew : ptrCur;
	wire [7:0] rdVal = dsRead(coreDs, memRdA, evtR);
	wire [7:0] bitMask = 8'h01 << bSel;
	wire [7:0] bitMod = opR[8] ? (rdVal & ~bitMask) : (rdVal | bitMask);
	// Only the bit class skips; bit 9 means other things in port and pointer opcodes.
	wire skipHit = (cls == CL_BIT) & opR[9] & (rdVal[bSel] ^ opR[8]);
	wire [8:0] shRes = shiftCalc(shK, srcD, cFlag);
	wire brTake = (opR[11:10] == BR_VC && !flagsR[FL_V]) ||
		(opR[11:10] == BR_IE && flagsR[FL_I]) || (opR[11:10] == BR_ID && !flagsR[FL_I]);
	wire [15:0] brTarget = pcR + {{9{opR[6]}}, opR[6:0]} + 16'h0001;
	wire twoCyc = cls == CL_IN || cls == CL_BIT || cls == CL_PTR || cls == CL_DISP ||
		(cls == CL_BR && brTake);
	wire start = busWr & selInstr & (stR == S_IDLE);
	// Core memory write for port writes and bit set or clear.
	wire weA = (ex && cls == CL_OUT) || (fin && cls == CL_BIT && !opR[9]);
	wire [7:0] wdA = (cls == CL_OUT) ? gprR[portD] : bitMod;
	wire [7:0] evtClr = ((weA && coreDs == EVT_DS) ? wdA : 8'h00) |
		((busWr && selMem && busDs == EVT_DS) ? hwdata[7:0] : 8'h00);
	wire [7:0] agree = ~(s2R ^ s3R);
	wire [7:0] rise = s2R & s3R & ~stbR;

	assign cpuFlags = flagsR;

	cib_dmem #(.DEPTH(DMEM_DEPTH), .AW(AW)) uMem (
		.sys_clk(sys_clk),
		.weA(weA),
		.addrA(coreDs[AW-1:0]),
		.wdA(wdA),
		.rdA(memRdA),
		.weB(busWr & selMem),
		.addrB(addrB),
		.wdB(hwdata[7:0]),
		.rdB(memRdB)
	);

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	// Every transfer gets one wait state; data is answered from a register.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			accR <= 1'b0;
			wrR <= 1'b0;
			addrR <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
		end else if (take) begin
			accR <= 1'b1;
			wrR <= hwrite & (hsize == HSIZE_WORD);
			addrR <= haddr;
			hreadyout <= 1'b0;
		end else if (accR) begin
			accR <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= wrR ? 32'h0000_0000 : busRd;
		end
	end

	// Event pins pass three flops; a level counts once stages two and three agree.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s1R <= 8'h00;
			s2R <= 8'h00;
			s3R <= 8'h00;
			stbR <= 8'h00;
			evtR <= 8'h00;
		end else begin
			s1R <= evtIn;
			s2R <= s1R;
			s3R <= s2R;
			stbR <= (stbR & ~agree) | (s2R & agree);
			evtR <= (evtR & ~evtClr) | rise;
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// One execute cycle, plus a finish cycle for memory reads and taken branches.
	always_comb begin
		stNxt = S_IDLE;
		unique case (stR)
			S_IDLE: stNxt = start ? S_EXEC : S_IDLE;
			S_EXEC: stNxt = twoCyc ? S_FIN : S_IDLE;
			default: stNxt = S_IDLE;
		endcase
	end

	// Architectural state; core updates follow bus writes so the core wins.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stR <= S_IDLE;
			busy <= 1'b0;
			opR <= 16'h0000;
			pcR <= PC_RST;
			flagsR <= FLAGS_RST;
			cycR <= 2'h0;
			illR <= 1'b0;
			dropR <= 1'b0;
			for (int i = 0; i < 32; i++) begin
				gprR[i] <= 8'h00;
			end
		end else begin
			stR <= stNxt;
			busy <= (stNxt != S_IDLE);
			illR <= (ex && !legal) || (illR && !(busWr && selStat && hwdata[ST_ILL]));
			dropR <= (busWr && selInstr && stR != S_IDLE) ||
				(dropR && !(busWr && selStat && hwdata[ST_DROP]));
			if (start) begin
				opR <= hwdata[15:0];
			end
			if (busWr && selPc && stR == S_IDLE) begin
				pcR <= hwdata[15:0];
			end
			if (busWr && selGpr) begin
				gprR[addrR[6:2]] <= hwdata[7:0];
			end
			if (ex && !twoCyc) begin
				cycR <= 2'h1;
				pcR <= pcR + 16'h0001;
			end
			if (ex) begin
				case (cls)
					CL_SH: if (legal) begin
						gprR[dSel] <= shRes[7:0];
						flagsR[FL_C] <= shRes[8];
						flagsR[FL_N] <= shRes[7];
						flagsR[FL_Z] <= (shRes[7:0] == 8'h00);
						flagsR[FL_V] <= shRes[7] ^ shRes[8];
					end
					CL_FLG: flagsR[bSel] <= ~fClr;
					CL_TBIT: if (opR[8]) begin
						gprR[tReg][bSel] <= flagsR[FL_T];
					end else begin
						flagsR[FL_T] <= tBit;
					end
					default: begin
					end
				endcase
			end
			if (fin) begin
				cycR <= 2'h2;
				pcR <= (cls == CL_BR) ? brTarget : pcR + (skipHit ? 16'h0002 : 16'h0001);
				if (cls == CL_PTR && (pMode == PM_POST || pMode == PM_PRE)) begin
					gprR[pLo | 5'h01] <= ptrNew[15:8];
					gprR[pLo] <= ptrNew[7:0];
				end
				if (cls == CL_IN) begin
					gprR[portD] <= rdVal;
				end
				if (cls == CL_PTR || cls == CL_DISP) begin
					gprR[dSel] <= rdVal;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// bit address range
	property p_bit_range;
		@(posedge sys_clk) disable iff (rst)
		ex && cls == CL_BIT |-> coreDs >= IO_DS_OFS && coreDs < IO_DS_OFS + 16'h0020;
	endproperty
	a_bit_range: assert property (p_bit_range) else $error("Bit op outside low I/O.");
	property p_rmw_whole;
		@(posedge sys_clk) disable iff (rst)
		fin && cls == CL_BIT && !opR[9] |-> weA && ((wdA ^ rdVal) & ~bitMask) == 8'h00;
	endproperty
	a_rmw_whole: assert property (p_rmw_whole) else $error("Bit op altered other bits.");
	property p_bit_clear;
		@(posedge sys_clk) disable iff (rst)
		ex && cls == CL_BIT && pMode == BIT_CLR |=> fin && weA && !wdA[bSel] &&
			flagsR == $past(flagsR) ##1 stR == S_IDLE;
	endproperty
	a_bit_clear: assert property (p_bit_clear) else $error("Bit clear wrong.");
	property p_w1c;
		@(posedge sys_clk) disable iff (rst)
		weA && coreDs == EVT_DS && wdA[0] && !rise[0] |=> !evtR[0];
	endproperty
	a_w1c: assert property (p_w1c) else $error("Event flag not cleared by one.");
	property p_port_map;
		@(posedge sys_clk) disable iff (rst)
		ex && (cls == CL_IN || cls == CL_OUT) |-> coreDs >= IO_DS_OFS && coreDs < EXT_IO_LO;
	endproperty
	a_port_map: assert property (p_port_map) else $error("Port address out of map.");
	property p_br_taken;
		@(posedge sys_clk) disable iff (rst)
		ex && cls == CL_BR && brTake |=> fin ##1 stR == S_IDLE && pcR == $past(brTarget, 2);
	endproperty
	a_br_taken: assert property (p_br_taken) else $error("Taken branch wrong.");
	property p_br_not;
		@(posedge sys_clk) disable iff (rst)
		ex && cls == CL_BR && !brTake |=> stR == S_IDLE && pcR == $past(pcR) + 16'h0001;
	endproperty
	a_br_not: assert property (p_br_not) else $error("Untaken branch wrong.");
	property p_shl;
		@(posedge sys_clk) disable iff (rst)
		ex && cls == CL_SH && shK == SH_LSL |=> gprR[$past(dSel)] == ($past(srcD) << 1) &&
			flagsR[FL_C] == $past(srcTop) && stR == S_IDLE;
	endproperty
	a_shl: assert property (p_shl) else $error("Logical shift up wrong.");
	property p_ror;
		@(posedge sys_clk) disable iff (rst)
		ex && cls == CL_SH && shK == SH_ROR |=> gprR[$past(dSel)][7] == $past(cFlag) &&
			(gprR[$past(dSel)] & 8'h7f) == ($past(srcD) >> 1) && flagsR[FL_C] == $past(srcBot);
	endproperty
	a_ror: assert property (p_ror) else $error("Rotate down wrong.");
	property p_asr;
		@(posedge sys_clk) disable iff (rst)
		ex && cls == CL_SH && shK == SH_ASR |=> flagsR[FL_C] == $past(srcBot) &&
			gprR[$past(dSel)] == (($past(srcD) >> 1) | ($past(srcD) & 8'h80));
	endproperty
	a_asr: assert property (p_asr) else $error("Arithmetic shift wrong.");
	property p_flag;
		@(posedge sys_clk) disable iff (rst)
		ex && cls == CL_FLG |=> flagsR[$past(bSel)] == !$past(fClr) &&
			(flagsR & ~$past(bitMask)) == ($past(flagsR) & ~$past(bitMask));
	endproperty
	a_flag: assert property (p_flag) else $error("Flag op wrong.");
	property p_bst;
		@(posedge sys_clk) disable iff (rst)
		ex && cls == CL_TBIT && !opR[8] |=> flagsR[FL_T] == $past(tBit) && stR == S_IDLE;
	endproperty
	a_bst: assert property (p_bst) else $error("Bit store wrong.");
	property p_post_inc;
		@(posedge sys_clk) disable iff (rst)
		ex && cls == CL_PTR && pMode == PM_POST && dSel < PTR_X_LO |=>
			fin ##1 ptrCur == $past(ptrCur, 2) + 16'h0001;
	endproperty
	a_post_inc: assert property (p_post_inc) else $error("Post-increment wrong.");
	property p_disp;
		@(posedge sys_clk) disable iff (rst)
		ex && cls == CL_DISP && dSel < PTR_X_LO |=>
			fin ##1 ptrCur == $past(ptrCur, 2) && gprR[dSel] == $past(rdVal);
	endproperty
	a_disp: assert property (p_disp) else $error("Displaced load wrong.");
endmodule

// ==== include/cib_pkg.sv ====
// Constants for the bit, shift, flag and pointer-load execution block.
// Assumes a 32-bit AHB-Lite register bus and an 8-bit core data path.
package cib_pkg;
	// Bus register byte addresses.
	localparam logic [31:0] ADDR_INSTR = 32'h0000_0000;
	localparam logic [31:0] ADDR_STAT = 32'h0000_0004;
	localparam logic [31:0] ADDR_PC = 32'h0000_0008;
	localparam logic [31:0] GPR_BASE = 32'h0000_0100;
	localparam logic [31:0] MEM_BASE = 32'h0000_0800;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// Data space layout.
	localparam int DMEM_DEPTH = 512;
	localparam logic [15:0] IO_DS_OFS = 16'h0020;
	localparam logic [15:0] EXT_IO_LO = 16'h0060;
	localparam logic [5:0] EVT_IO = 6'h16;
	localparam logic [15:0] EVT_DS = {10'h000, EVT_IO} + IO_DS_OFS;
	// Reset values.
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [15:0] PC_RST = 16'h0000;
	// Status flag positions.
	localparam logic [2:0] FL_C = 3'h0;
	localparam logic [2:0] FL_Z = 3'h1;
	localparam logic [2:0] FL_N = 3'h2;
	localparam logic [2:0] FL_V = 3'h3;
	localparam logic [2:0] FL_T = 3'h6;
	localparam logic [2:0] FL_I = 3'h7;
	// Status register clear bits.
	localparam int ST_ILL = 9;
	localparam int ST_DROP = 10;
	// Instruction classes in bits 15:12.
	localparam logic [3:0] CL_IN = 4'h0;
	localparam logic [3:0] CL_OUT = 4'h1;
	localparam logic [3:0] CL_BIT = 4'h2;
	localparam logic [3:0] CL_BR = 4'h3;
	localparam logic [3:0] CL_SH = 4'h4;
	localparam logic [3:0] CL_FLG = 4'h5;
	localparam logic [3:0] CL_TBIT = 4'h6;
	localparam logic [3:0] CL_PTR = 4'h7;
	localparam logic [3:0] CL_DISP = 4'h8;
	// Sub-codes.
	localparam logic [1:0] BIT_CLR = 2'h1;
	localparam logic [1:0] BR_VC = 2'h0;
	localparam logic [1:0] BR_IE = 2'h1;
	localparam logic [1:0] BR_ID = 2'h2;
	localparam logic [2:0] SH_LSL = 3'h0;
	localparam logic [2:0] SH_LSR = 3'h1;
	localparam logic [2:0] SH_ROL = 3'h2;
	localparam logic [2:0] SH_ROR = 3'h3;
	localparam logic [2:0] SH_ASR = 3'h4;
	localparam logic [1:0] PM_POST = 2'h1;
	localparam logic [1:0] PM_PRE = 2'h2;
	localparam logic [4:0] PTR_X_LO = 5'h1a;
	localparam logic [4:0] PTR_Y_LO = 5'h1c;
	localparam logic [4:0] PTR_Z_LO = 5'h1e;
	// Execution states.
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_EXEC = 2'b01,
		S_FIN = 2'b10
	} cib_state_t;
endpackage

// ==== hdl/cib_dmem.sv ====
// Two-port byte memory holding the data space of the core.
// Assumes both ports share sys_clk; read data is registered.
`timescale 1ns/1ps
module cib_dmem #(
	parameter int DEPTH = 512,
	parameter int AW = 9
) (
	// Clock.
	input wire logic sys_clk,
	// Core port.
	input wire logic weA,
	input wire logic [AW-1:0] addrA,
	input wire logic [7:0] wdA,
	output logic [7:0] rdA,
	// Bus port.
	input wire logic weB,
	input wire logic [AW-1:0] addrB,
	input wire logic [7:0] wdB,
	output logic [7:0] rdB
);
	logic [7:0] mem [DEPTH];

	// Writes then registered reads; the core port wins a same-address clash.
	always_ff @(posedge sys_clk) begin
		if (weB) begin
			mem[addrB] <= wdB;
		end
		if (weA) begin
			mem[addrA] <= wdA;
		end
		rdA <= mem[addrA];
		rdB <= mem[addrB];
	end
endmodule

// ==== verification/cib_evt_model.sv ====
// Event source standing in for the peripherals that raise sticky flags.
// Assumes the bench requests a pulse on fire; all timing is on sys_clk.
`timescale 1ns/1ps
module cib_evt_model (
	// Clock.
	input wire logic sys_clk,
	// Pulse request.
	input wire logic [7:0] fire,
	// Event pins.
	output logic [7:0] evtIn
);
	logic [7:0] hold_r;

	// Hold each requested pin two cycles, then drop it, so a flag sees a single rise.
	// sticky flag source
	always @(posedge sys_clk) begin
		hold_r <= fire;
		evtIn <= fire | hold_r;
	end
endmodule

// ==== verification/cib_core_bench.sv ====
// Self-checking bench for the bit, shift, flag and pointer-load execution block.
// Assumes one AHB-Lite master (this bench) and the event model on the pins.
`timescale 1ns/1ps
module cib_core_bench
	import cib_pkg::*;
;
	logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, busy;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] evtIn, cpuFlags, fire;
	int badCount, checksDone, cycles;

	// -----------------------------------------------------------------
	// Design, event source and clock
	// -----------------------------------------------------------------
	cib_core dut_u (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.evtIn(evtIn), .cpuFlags(cpuFlags), .busy(busy));
	cib_evt_model evt_u (.sys_clk(sys_clk), .fire(fire), .evtIn(evtIn));

	// Clock of 40 ns period.
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Cut a hang short well beyond the expected run length.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			badCount++;
			summarize();
		end
	end

	// -----------------------------------------------------------------
	// Shared tasks
	// -----------------------------------------------------------------
	task automatic summarize();
		if (badCount == 0 && checksDone > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			badCount++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One single AHB-Lite transfer; read data is taken at the completing edge.
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rdv);
		@(posedge sys_clk);
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		bus(1'b0, a, 32'h0000_0000, d);
	endtask

	// Start one instruction and wait until the core is idle again.
	task automatic exec(input logic [15:0] op);
		wr(ADDR_INSTR, {16'h0000, op});
		repeat (2) @(posedge sys_clk);
		while (busy !== 1'b0) @(posedge sys_clk);
	endtask

	function automatic logic [31:0] ga(input int n);
		return GPR_BASE + 32'(4 * n);
	endfunction

	function automatic logic [31:0] ma(input logic [15:0] a);
		return MEM_BASE + {14'h0000, a, 2'b00};
	endfunction

	// Expected carry and result of a shift, worked from the shift rules.
	function automatic logic [8:0] shexp(input logic [2:0] s, input logic [7:0] x, input logic c);
		case (s)
			3'h0: return {x[7], x[6:0], 1'b0};
			3'h1: return {x[0], 1'b0, x[7:1]};
			3'h2: return {x[7], x[6:0], c};
			3'h3: return {x[0], c, x[7:1]};
			default: return {x[0], x[7], x[7:1]};
		endcase
	endfunction

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task automatic t_reset();
		rd(ADDR_STAT, v);
		chk("stat pc", v[31:16], 32'h0);
		chk("stat low", v[10:0], 32'h0);
		rd(32'h0000_0040, v);
		chk("unmapped", v, 32'h0);
		chk("hresp", hresp, 32'h0);
		// An unused class raises the sticky illegal bit, and a one written clears it.
		exec(16'h9000);
		rd(ADDR_STAT, v);
		chk("illegal flag", v[9], 32'h1);
		wr(ADDR_STAT, 32'h0000_0200);
		rd(ADDR_STAT, v);
		chk("illegal clear", v[9], 32'h0);
	endtask

	task automatic t_flags();
		for (int s = 0; s < 8; s++) begin
			exec({12'h500, 1'b0, 3'(s)});
			chk("flag set", cpuFlags, 32'(1 << s));
			exec({12'h500, 1'b1, 3'(s)});
			chk("flag clear", cpuFlags, 32'h0);
		end
	endtask

	// Branch kinds with all flags clear: overflow clear and irq off are taken.
	task automatic t_branch();
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_PC, 32'h0000_0020);
			exec({4'h3, 2'(c), 3'h0, 7'h7d});
			rd(ADDR_STAT, v);
			chk("branch pc", v[31:16], (c % 2 == 0 && c != 3) ? 32'h1e : 32'h21);
			chk("branch cycles", v[13:12], (c % 2 == 0) ? 32'h2 : 32'h1);
		end
	endtask

	// Carry clear shifts 0x81 and carry set shifts 0x01, so zero results are reached too.
	task automatic t_shift();
		logic [8:0] e;
		logic [7:0] x;
		for (int s = 0; s < 5; s++) begin
			for (int c = 0; c < 2; c++) begin
				x = (c == 0) ? 8'h81 : 8'h01;
				wr(ga(1), {24'h000000, x});
				exec({12'h500, c == 0, 3'h0});
				exec({5'h08, 3'(s), 8'h01});
				e = shexp(3'(s), x, c == 1);
				rd(ga(1), v);
				chk("shift result", v, {24'h0, e[7:0]});
				chk("shift flags", cpuFlags[3:0], {e[7] ^ e[8], e[7], e[7:0] == 0, e[8]});
			end
		end
	endtask

	task automatic t_tbit();
		wr(ga(7), 32'h04);
		wr(ga(8), 32'h00);
		exec({7'h30, 1'b0, 5'd7, 3'd2});
		chk("bit to T", cpuFlags[FL_T], 32'h1);
		exec({7'h30, 1'b1, 5'd8, 3'd5});
		rd(ga(8), v);
		chk("T to bit", v, 32'h20);
	endtask

	task automatic t_io();
		logic [7:0] f;
		wr(ma(16'h25), 32'ha5);
		wr(ma(16'h3f), 32'h00);
		exec({4'h0, 1'b0, 5'd2, 6'h05});
		rd(ga(2), v);
		chk("port read", v, 32'ha5);
		f = cpuFlags;
		exec({6'h08, 2'b01, 5'h05, 3'h0});
		rd(ma(16'h25), v);
		chk("bit clear", v, 32'ha4);
		chk("bit clear flags", cpuFlags, {24'h000000, f});
		rd(ADDR_STAT, v);
		chk("bit clear cycles", v[13:12], 32'h2);
		exec({6'h08, 2'b00, 5'h05, 3'h1});
		rd(ma(16'h25), v);
		chk("bit set", v, 32'ha6);
		exec({6'h08, 2'b00, 5'h1f, 3'h7});
		rd(ma(16'h3f), v);
		chk("bit set top", v, 32'h80);
		wr(ADDR_PC, 32'h0000_0040);
		exec({6'h08, 2'b10, 5'h05, 3'h1});
		exec({6'h08, 2'b11, 5'h05, 3'h1});
		rd(ADDR_STAT, v);
		chk("skip pc", v[31:16], 32'h43);
		exec({4'h1, 1'b0, 5'd2, 6'h3f});
		rd(ma(16'h5f), v);
		chk("port write top", v, 32'ha5);
	endtask

	task automatic t_event();
		fire <= 8'h01;
		@(posedge sys_clk);
		fire <= 8'h00;
		repeat (8) @(posedge sys_clk);
		rd(ma(EVT_DS), v);
		chk("event raised", v, 32'h01);
		exec({6'h08, 2'b00, EVT_IO[4:0], 3'h1});
		rd(ma(EVT_DS), v);
		chk("event after bit set", v, 32'h00);
		fire <= 8'h01;
		@(posedge sys_clk);
		fire <= 8'h00;
		repeat (8) @(posedge sys_clk);
		wr(ma(EVT_DS), 32'h01);
		rd(ma(EVT_DS), v);
		chk("event write one", v, 32'h00);
	endtask

	// Three pointer loads started from PC 0x10 must leave PC at 0x13.
	task automatic t_ptr();
		wr(ADDR_PC, 32'h0000_0010);
		wr(ga(26), 32'h60);
		wr(ga(27), 32'h00);
		wr(ga(30), 32'h60);
		wr(ga(31), 32'h00);
		wr(ma(16'h60), 32'h11);
		wr(ma(16'h61), 32'h22);
		wr(ma(16'h63), 32'h33);
		exec({8'h71, 3'h0, 5'd3});
		rd(ga(3), v);
		chk("post-inc data", v, 32'h11);
		rd(ga(26), v);
		chk("post-inc ptr", v, 32'h61);
		exec({8'h70, 3'h0, 5'd5});
		rd(ga(5), v);
		chk("plain data", v, 32'h22);
		exec({8'h72, 3'h0, 5'd4});
		rd(ga(4), v);
		chk("pre-dec data", v, 32'h11);
		rd(ADDR_STAT, v);
		chk("ptr cycles", v[13:12], 32'h2);
		chk("ptr pc", v[31:16], 32'h13);
		exec({4'h8, 1'b1, 6'd3, 5'd6});
		rd(ga(6), v);
		chk("disp data", v, 32'h33);
		rd(ga(30), v);
		chk("disp ptr", v, 32'h60);
	endtask

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		fire = 8'h00;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_flags();
		t_branch();
		t_shift();
		t_tbit();
		t_io();
		t_event();
		t_ptr();
		summarize();
	end
endmodule
